// *** design/ctpg_pkg.sv ***
/*
  Shared constants for the camera trigger pulse generator: register
  offsets, field positions, reset values and widths.
  Assumes a 32-bit classic Wishbone register bus and a single clock.
*/
package ctpg_pkg;

  // register map, byte addresses of aligned 32-bit words
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_FREQ    = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_WIDTH0  = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_WIDTH1  = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_OFFSET1 = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_TIME    = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_TSTAMP  = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 5'h1c;

  // control fields
  localparam int CTRL_W   = 3;
  localparam int CTRL_EN0 = 0;
  localparam int CTRL_EN1 = 1;
  localparam int CTRL_PPS = 2;

  // status fields
  localparam int STAT_W        = 4;
  localparam int STAT_OUT0     = 0;
  localparam int STAT_OUT1     = 1;
  localparam int STAT_PPS_IN   = 2;
  localparam int STAT_PPS_SEEN = 3;

  // field widths
  localparam int FREQ_W = 8;
  localparam int MS_W   = 16;
  localparam int TIME_W = 32;
  localparam int DATA_W = 32;
  localparam int SEL_W  = 4;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST   = 3'h0;
  localparam logic [FREQ_W-1:0] FREQ_RST   = 8'h0a;
  localparam logic [MS_W-1:0]   WIDTH_RST  = 16'h0001;
  localparam logic [MS_W-1:0]   OFFSET_RST = 16'h0000;

  // frequency range in hertz
  localparam logic [FREQ_W-1:0] FREQ_MIN_HZ = 8'h06;
  localparam logic [FREQ_W-1:0] FREQ_MAX_HZ = 8'h32;

  // pulse width and offset unit
  localparam int UNIT_MS  = 1;
  localparam int MS_PER_S = 1000;
  localparam int CLK_HZ_DEFAULT = 40_000_000;

endpackage

// *** design/ctpg_top.sv ***
/*
  Camera trigger pulse generator with a free-running time counter,
  reached over a classic Wishbone slave.
  Summary of operation is listed below. Assumes one 40 MHz clock, an
  asynchronous active-low reset and an external wire resolver for the
  shared trigger 1 / PPS pin.
  Assumes software keeps the frequency inside 6 to 50 Hz; values
  outside it are clamped, not refused.
  The time counter counts clock cycles and wraps silently; software
  that needs longer spans extends it itself.
  Pulse widths and offsets are counted in whole milliseconds, so the
  finest step is MS_CYCLES clocks.
  Trigger 1 pulses that run past the next period start are cut there, unless offset1 is 0.
  Settings are best written while channel 0 is off.
*/
// Implementation choices: register access over Wishbone and the register offsets.
// Summary of operation
// - two channels, each with own enable
// - channel 0 rate from 6 to 50 Hz
// - channel 0 high exactly configured milliseconds
// - outputs active high, rest low
// - channel 1 idle unless channel 0 enabled
// - channel 1 repeats at channel 0 rate
// - channel 1 rises offset after channel 0
// - channel 1 has its own width
// - PPS enabled: trigger 1 pin not driven
// - PPS pulse zeroes the time counter
// - timestamp latched for every triggered frame
`timescale 1ns/1ps
module ctpg_top
  import ctpg_pkg::*;
#(
  parameter int CLK_HZ    = CLK_HZ_DEFAULT,
  parameter int MS_CYCLES = CLK_HZ * UNIT_MS / MS_PER_S,
  parameter int ACC_W     = 27
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [SEL_W-1:0]  wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  // trigger 0 pin
  output logic                   trig0_o,
  // trigger 1 / pps shared pin
  input  wire logic              trig1_i,
  output logic                   trig1_o,
  output logic                   trig1_oe
);

  localparam int MSC_W = $clog2(MS_CYCLES + 1);
  localparam logic [ACC_W-1:0] CLK_LIM  = ACC_W'(CLK_HZ);
  localparam logic [MSC_W-1:0] MS_LAST  = MSC_W'(MS_CYCLES - 1);
  localparam logic [MS_W-1:0]  EL_SAT   = {MS_W{1'b1}};

  if (CLK_HZ < MS_PER_S || MS_CYCLES < 1 || CLK_HZ >= (2 ** (ACC_W - 1))) begin : g_chk
    $error("ctpg_top: clock rate does not fit the accumulator or ms divider");
  end

  // configuration registers
  logic [CTRL_W-1:0] ctrl;
  logic [FREQ_W-1:0] freq;
  logic [MS_W-1:0]   width0;
  logic [MS_W-1:0]   width1;
  logic [MS_W-1:0]   offset1;

  // time base state
  logic [ACC_W-1:0]  acc;
  logic              en0_d;
  logic [MSC_W-1:0]  ms_cnt;
  logic [MS_W-1:0]   el_ms;
  logic [TIME_W-1:0] time_cnt;
  logic [TIME_W-1:0] tstamp;
  logic              pps_seen;

  // pps pin synchroniser and edge stage
  logic              pps_s1;
  logic              pps_s2;
  logic              pps_s3;

  // bus decode
  logic [ADDR_W-1:0] word_adr;
  logic              wb_req;
  logic              wb_wr;
  logic [DATA_W-1:0] byte_m;
  logic              wr_ctrl;
  logic              wr_freq;
  logic              wr_width0;
  logic              wr_width1;
  logic              wr_offset1;
  logic              wr_status;
  logic [DATA_W-1:0] ctrl_new;
  logic [DATA_W-1:0] freq_new;
  logic [DATA_W-1:0] width0_new;
  logic [DATA_W-1:0] width1_new;
  logic [DATA_W-1:0] offset1_new;
  logic [DATA_W-1:0] rd_data;

  // pulse core
  logic              en0;
  logic              en1;
  logic              pps_en;
  logic [FREQ_W-1:0] freq_eff;
  logic [ACC_W-1:0]  acc_sum;
  logic              wrap;
  logic              start;
  logic [ACC_W-1:0]  next_acc;
  logic              ms_done;
  logic [MSC_W-1:0]  next_ms_cnt;
  logic [MS_W-1:0]   next_el;
  logic [MS_W:0]     off_end;
  logic              next_out0;
  logic              next_out1;
  logic              pps_rise;
  logic [TIME_W-1:0] next_time;
  logic              pps_clr;

  assign word_adr = {wb_adr_i[ADDR_W-1:2], 2'b00};
  assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr    = wb_req & wb_we_i;
  assign byte_m   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  assign wr_ctrl    = wb_wr && (word_adr == OFF_CTRL);
  assign wr_freq    = wb_wr && (word_adr == OFF_FREQ);
  assign wr_width0  = wb_wr && (word_adr == OFF_WIDTH0);
  assign wr_width1  = wb_wr && (word_adr == OFF_WIDTH1);
  assign wr_offset1 = wb_wr && (word_adr == OFF_OFFSET1);
  assign wr_status  = wb_wr && (word_adr == OFF_STATUS);

  // byte lanes not selected keep their old contents
  assign ctrl_new    = ({{(DATA_W-CTRL_W){1'b0}}, ctrl} & ~byte_m) | (wb_dat_i & byte_m);
  assign freq_new    = ({{(DATA_W-FREQ_W){1'b0}}, freq} & ~byte_m) | (wb_dat_i & byte_m);
  assign width0_new  = ({{(DATA_W-MS_W){1'b0}}, width0} & ~byte_m) | (wb_dat_i & byte_m);
  assign width1_new  = ({{(DATA_W-MS_W){1'b0}}, width1} & ~byte_m) | (wb_dat_i & byte_m);
  assign offset1_new = ({{(DATA_W-MS_W){1'b0}}, offset1} & ~byte_m) | (wb_dat_i & byte_m);

  // write-one-to-clear on the sticky pps flag
  assign pps_clr = wr_status & wb_sel_i[0] & wb_dat_i[STAT_PPS_SEEN];

  always_comb begin
    case (word_adr)
      OFF_CTRL:    rd_data = {{(DATA_W-CTRL_W){1'b0}}, ctrl};
      OFF_FREQ:    rd_data = {{(DATA_W-FREQ_W){1'b0}}, freq};
      OFF_WIDTH0:  rd_data = {{(DATA_W-MS_W){1'b0}}, width0};
      OFF_WIDTH1:  rd_data = {{(DATA_W-MS_W){1'b0}}, width1};
      OFF_OFFSET1: rd_data = {{(DATA_W-MS_W){1'b0}}, offset1};
      OFF_TIME:    rd_data = time_cnt;
      OFF_TSTAMP:  rd_data = tstamp;
      OFF_STATUS:  rd_data = {{(DATA_W-STAT_W){1'b0}}, pps_seen, pps_s2, trig1_o, trig0_o};
      default:     rd_data = '0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // settings, each taken whole or by byte lane
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= ctrl_new[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      freq <= FREQ_RST;
    end else if (wr_freq) begin
      freq <= freq_new[FREQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      width0 <= WIDTH_RST;
    end else if (wr_width0) begin
      width0 <= width0_new[MS_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      width1 <= WIDTH_RST;
    end else if (wr_width1) begin
      width1 <= width1_new[MS_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      offset1 <= OFFSET_RST;
    end else if (wr_offset1) begin
      offset1 <= offset1_new[MS_W-1:0];
    end
  end

  assign en0    = ctrl[CTRL_EN0];
  assign en1    = ctrl[CTRL_EN1];
  assign pps_en = ctrl[CTRL_PPS];

  // out-of-range rates are clamped rather than refused
  assign freq_eff = (freq < FREQ_MIN_HZ) ? FREQ_MIN_HZ :
                    (freq > FREQ_MAX_HZ) ? FREQ_MAX_HZ : freq;

  // phase accumulator: exact long-term rate, no divider needed
  assign acc_sum  = acc + {{(ACC_W-FREQ_W){1'b0}}, freq_eff};
  assign wrap     = acc_sum >= CLK_LIM;
  // one shared period start for both channels
  assign start    = en0 & (wrap | ~en0_d);
  assign next_acc = !en0 ? '0 : wrap ? acc_sum - CLK_LIM : acc_sum;

  // millisecond divider restarts at each period start
  assign ms_done     = ms_cnt == MS_LAST;
  assign next_ms_cnt = (start || ms_done) ? '0 : ms_cnt + 1'b1;
  assign next_el     = start ? '0 :
                       (ms_done && el_ms != EL_SAT) ? el_ms + 1'b1 : el_ms;

  assign off_end   = {1'b0, offset1} + {1'b0, width1};
  assign next_out0 = en0 & (next_el < width0);
  assign next_out1 = en0 & en1 & ~pps_en &
                     (next_el >= offset1) & ({1'b0, next_el} < off_end);

  assign pps_rise  = pps_en & pps_s2 & ~pps_s3;
  assign next_time = pps_rise ? '0 : time_cnt + 1'b1;

  // period and millisecond time base
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en0_d <= 1'b0;
    end else begin
      en0_d <= en0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= next_ms_cnt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      el_ms <= '0;
    end else begin
      el_ms <= next_el;
    end
  end

  // pins registered so no decode glitch reaches a camera
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig0_o <= 1'b0;
    end else begin
      trig0_o <= next_out0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig1_o <= 1'b0;
    end else begin
      trig1_o <= next_out1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig1_oe <= 1'b0;
    end else begin
      trig1_oe <= ~pps_en;
    end
  end

  // pin is asynchronous: two flops before anything looks at it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pps_s1 <= 1'b0;
      pps_s2 <= 1'b0;
      pps_s3 <= 1'b0;
    end else begin
      pps_s1 <= trig1_i;
      pps_s2 <= pps_s1;
      pps_s3 <= pps_s2;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      time_cnt <= '0;
    end else begin
      time_cnt <= next_time;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tstamp <= '0;
    end else if (start) begin
      tstamp <= time_cnt;
    end
  end

  // a new pulse beats a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pps_seen <= 1'b0;
    end else if (pps_rise) begin
      pps_seen <= 1'b1;
    end else if (pps_clr) begin
      pps_seen <= 1'b0;
    end
  end

endmodule

// *** testbench/ctpg_camera_model.sv ***
/* two cameras on the trigger pins and a pps source on the shared pin.
   assumes the bench resolves the shared pin and feeds its level back */
`timescale 1ns/1ps
module ctpg_camera_model (
  // pins
  input  logic clk,
  input  logic trig0,
  input  logic pin1,
  output logic pps_drv,
  // bench control and counts
  input  logic clr,
  input  logic pps_go,
  output int   n0,
  output int   n1,
  output int   gap0
);
  bit p0, p1;
  int age, pc;
  // source rests low when idle, as if pulled down
  assign pps_drv = pc != 0;
  always @(posedge clk) begin
    p0 <= trig0;
    p1 <= pin1;
    age <= age + 1;
    pc <= pps_go ? 40 : (pc != 0 ? pc - 1 : 0);
    if (clr) begin
      n0 <= 0;
      n1 <= 0;
    end else begin
      if (trig0 === 1'b1 && !p0) begin
        n0 <= n0 + 1;
        gap0 <= age;
        age <= 1;
      end
      if (pin1 === 1'b1 && !p1)
        n1 <= n1 + 1;
    end
  end
endmodule

// *** testbench/ctpg_top_assertions.sv ***
/* port checker for ctpg_top, bound into the top module.
   assumes settings are written with all four byte enables */
`timescale 1ns/1ps
module ctpg_chk
  import ctpg_pkg::*;
#(parameter int MS_CYCLES = 10) (
  // clock, reset, bus
  input logic              clk,
  input logic              arst_n,
  input logic              wb_cyc_i,
  input logic              wb_stb_i,
  input logic              wb_we_i,
  input logic [ADDR_W-1:0] wb_adr_i,
  input logic [SEL_W-1:0]  wb_sel_i,
  input logic [DATA_W-1:0] wb_dat_i,
  input logic              wb_ack_o,
  // pins
  input logic              trig0_o,
  input logic              trig1_o,
  input logic              trig1_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [CTRL_W-1:0] ctl;
  logic [MS_W-1:0]   w0, w1, off;
  int                hi0, hi1, since0;
  wire take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hf;
  wire run1 = ctl[CTRL_EN0] && ctl[CTRL_EN1] && !ctl[CTRL_PPS];
  // shadow settles on the same edge as the slave's own registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl <= CTRL_RST;
      w0 <= WIDTH_RST;
      w1 <= WIDTH_RST;
      off <= OFFSET_RST;
    end else if (take) begin
      case (wb_adr_i)
        OFF_CTRL:    ctl <= wb_dat_i[CTRL_W-1:0];
        OFF_WIDTH0:  w0 <= wb_dat_i[MS_W-1:0];
        OFF_WIDTH1:  w1 <= wb_dat_i[MS_W-1:0];
        OFF_OFFSET1: off <= wb_dat_i[MS_W-1:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi0 <= 0;
      hi1 <= 0;
      since0 <= 0;
    end else begin
      hi0 <= trig0_o ? hi0 + 1 : 0;
      hi1 <= trig1_o ? hi1 + 1 : 0;
      since0 <= $rose(trig0_o) ? 1 : since0 + 1;
    end
  end
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  oe_released_a: assert property (ctl[CTRL_PPS] [*2] |-> !trig1_oe)
    else $error("shared pin driven in pps mode");
  oe_driven_a: assert property ((!ctl[CTRL_PPS]) [*2] |-> trig1_oe)
    else $error("shared pin not driven");
  trig1_idle_a: assert property ((!run1) [*2] |-> !trig1_o)
    else $error("trigger 1 active while off");
  width0_exact_a: assert property ($fell(trig0_o) && ctl[CTRL_EN0] |-> hi0 == w0 * MS_CYCLES)
    else $error("trigger 0 width wrong");
  width1_exact_a: assert property ($fell(trig1_o) && run1 |->
    (hi1 == w1 * MS_CYCLES) or ##[0:1] $rose(trig0_o)) else $error("trigger 1 width wrong");
  offset_lag_a: assert property ($rose(trig1_o) |->
    ($rose(trig0_o) ? off == 0 : since0 == off * MS_CYCLES)) else $error("trigger 1 lag wrong");
  reset_quiet_a: assert property ($rose(arst_n) |-> !trig0_o && !trig1_o && !trig1_oe)
    else $error("outputs not idle after reset");
  cover property ($rose(trig1_o));
  cover property ($fell(trig1_o) ##1 $rose(trig0_o));
  cover property (ctl[CTRL_PPS] && !trig1_oe);
endmodule
bind ctpg_top ctpg_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (.clk(clk), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .trig0_o(trig0_o),
  .trig1_o(trig1_o), .trig1_oe(trig1_oe));

// *** testbench/ctpg_top_tb.sv ***
/* self-checking bench for ctpg_top: a table of trigger setups, then reset,
   pps and timestamp cases; assumes the camera model beside it */
`timescale 1ns/1ps
module ctpg_top_tb;
  import ctpg_pkg::*;
  localparam int HZ = 10000;
  logic              clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, clr = 0, go = 0;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wd = '0, rdat, q, ts;
  logic              ack, t0, t1, oe, pps, pin;
  int                fails = 0, compares = 0, n0, n1, gap;
  int rows[6][8] = '{'{50, 2, 3, 5, 3, 200, 1, 1}, '{6, 1, 1, 0, 3, 1666, 1, 1},
    '{60, 2, 1, 0, 1, 200, 1, 0}, '{3, 1, 1, 0, 1, 1666, 1, 0},
    '{50, 2, 1, 0, 6, 200, 0, 0}, '{50, 2, 15, 15, 3, 200, 1, 1}};
  logic [ADDR_W-1:0] ra[5] = '{OFF_CTRL, OFF_FREQ, OFF_WIDTH0, OFF_WIDTH1, OFF_OFFSET1};
  int                rv[5] = '{0, 10, 1, 1, 0};
  assign pin = oe ? t1 : pps;
  always #12.5 clk = ~clk;
  ctpg_top #(.CLK_HZ(HZ), .MS_CYCLES(10)) i_dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .trig0_o(t0), .trig1_i(pin), .trig1_o(t1),
    .trig1_oe(oe));
  ctpg_camera_model i_cam (.clk(clk), .trig0(t0), .pin1(pin), .pps_drv(pps), .clr(clr),
    .pps_go(go), .n0(n0), .n1(n1), .gap0(gap));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; held until ack is sampled, then released
  task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    if (ack !== 1'b1) begin
      fails++;
      test_done;
    end
  endtask
  task automatic pps_pulse(input logic [31:0] c);
    wb(1, OFF_CTRL, c);
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (80) @(posedge clk);
    wb(0, OFF_TIME, 0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1;
    foreach (rows[i]) begin
      wb(1, OFF_CTRL, 0);
      wb(1, OFF_FREQ, rows[i][0]);
      wb(1, OFF_WIDTH0, rows[i][1]);
      wb(1, OFF_WIDTH1, rows[i][2]);
      wb(1, OFF_OFFSET1, rows[i][3]);
      clr <= 1;
      wb(1, OFF_CTRL, rows[i][4]);
      clr <= 0;
      repeat (2 * rows[i][5] + 60) @(posedge clk);
      chk("rise0", rows[i][6], n0 > 1);
      chk("rise1", rows[i][7], n1 > 1 && n0 - n1 < 2);
      chk("oe", !rows[i][4][2], oe);
      if (rows[i][6]) chk("period", 1, gap >= rows[i][5] - 1 && gap <= rows[i][5] + 1);
      $display("row %0d done", i);
    end
    arst_n <= 0;
    @(posedge clk);
    chk("t0 reset", 0, t0);
    chk("t1 reset", 0, t1);
    arst_n <= 1;
    foreach (rv[j]) begin
      wb(0, ra[j], 0);
      chk("reset value", rv[j], q);
    end
    wb(1, OFF_CTRL, 32'hffffffff);
    wb(0, OFF_CTRL, 0);
    chk("ctrl reserved", 7, q);
    $display("reset done");
    pps_pulse(4);
    chk("pps zero", 1, q > 70 && q < 95);
    wb(0, OFF_STATUS, 0);
    chk("pps seen", 1, q[STAT_PPS_SEEN]);
    pps_pulse(0);
    chk("pps off", 1, q > 150);
    $display("pps done");
    wb(1, OFF_CTRL, 1);
    repeat (300) @(posedge clk);
    wb(0, OFF_TSTAMP, 0);
    ts = q;
    wb(0, OFF_TIME, 0);
    chk("stamp", 1, ts != 0 && q - ts > 295 && q - ts < 320);
    $display("stamp done");
    test_done;
  end
endmodule
